// >>> core/css_pkg.sv
// constants shared by the charge safety supervisor
// Overview of operation
// - stop charging after 175 s without setpoints
// - any setpoint command restarts the timeout
// - after timeout, need both setpoints to resume
// - reset resumes charging at 128 mA default
// - on-phase ends after at most 10 ms
// - forced on-end gets a 1 us off-phase
// - off-time is a function of pack voltage
// - four temperature comparators drive four flags
// - open sense: flag, soft reset, pack absent
// - cold flag set, charging unaffected
// - hot flag latched until removal or reset
// - hot flag halts charging if halt enabled
// - grounded sense input sets short flag
// - temperature flags are evaluated independently
// - source switch hysteresis 300 mV on, 100 mV off
// - supply loss flag follows source comparator
// - load switch hysteresis 100 mV off, 300 mV on
// - unmasked status changes pull interrupt low
// - pack removal restores current setpoint default
package css_pkg;
	// clock and timing
	localparam int CLK_HZ        = 125_000_000;
	localparam int TICK_MS       = 1;
	localparam int TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
	localparam int TIMEOUT_S     = 175;
	localparam int TIMEOUT_TICKS = TIMEOUT_S * 1000 / TICK_MS;
	localparam int MAXON_MS      = 10;
	localparam int MAXON_CYC     = CLK_HZ / 1000 * MAXON_MS;
	localparam int DROP_OFF_NS   = 1000;
	localparam int DROP_OFF_CYC  = (CLK_HZ / 1_000_000) * DROP_OFF_NS / 1000;
	localparam int TOFF_VCYC     = 1375;  // volt-cycles of off-time for a fixed ripple
	localparam int PV_W          = 5;     // pack voltage code, one volt per step
	localparam int OFF_W         = 11;    // off-time counter width
	// register map
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  OFS_MODE   = 8'h00;
	localparam logic [7:0]  OFS_ISET   = 8'h04;
	localparam logic [7:0]  OFS_VSET   = 8'h08;
	localparam logic [7:0]  OFS_STATUS = 8'h0c;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// mode fields
	localparam int          MD_POR_BIT  = 0;
	localparam int          MD_HALT_BIT = 2;
	localparam int          MD_ACM_BIT  = 4;
	localparam int          MD_PKM_BIT  = 5;
	localparam int          MD_PFM_BIT  = 6;
	localparam logic [15:0] MODE_POR    = 16'h0004;
	// setpoint defaults and limits
	localparam logic [15:0] ISET_POR = 16'h0080;
	localparam logic [15:0] VSET_POR = 16'h4800;
	localparam logic [15:0] ISET_MIN = 16'h0080;
	localparam logic [15:0] VSET_MIN = 16'h0400;
	// status fields
	localparam int ST_CHG_BIT   = 0;
	localparam int ST_TMO_BIT   = 1;
	localparam int ST_SHORT_BIT = 8;
	localparam int ST_HOT_BIT   = 9;
	localparam int ST_COLD_BIT  = 10;
	localparam int ST_OPEN_BIT  = 11;
	localparam int ST_PF_BIT    = 13;
	localparam int ST_PACK_BIT  = 14;
	localparam int ST_AC_BIT    = 15;
endpackage : css_pkg

// >>> core/css_buck_if.sv
// link between the supervisor and its buck on/off timer
`timescale 1ns/100ps
`default_nettype none
interface css_buck_if;
	import css_pkg::*;
	logic            run;     // regulator allowed to switch
	logic [PV_W-1:0] pack_v;  // synchronised pack voltage code
	logic            trip;    // current loop asks for turn-off
	logic            hs;      // high side gate
	logic            ls;      // low side gate
	modport ctl (output run, pack_v, trip, input hs, ls);
	modport pwr (input run, pack_v, trip, output hs, ls);
endinterface : css_buck_if
`default_nettype wire

// >>> core/css_timeout.sv
// prescaled charge safety timer
`timescale 1ns/100ps
`default_nettype none
module css_timeout #(
	parameter int TICK_CYC    = css_pkg::TICK_CYC,
	parameter int LIMIT_TICKS = css_pkg::TIMEOUT_TICKS
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// control
	input  wire logic run,
	input  wire logic restart,
	// one-cycle pulse at terminal count
	output logic      expire
);
	import css_pkg::*;
	logic [31:0] pre_r;   // cycles within one tick
	logic [31:0] tick_r;  // ticks since last restart
	logic        tick;
	assign tick = (pre_r == 32'(TICK_CYC - 1));
	// prescaler and tick counter, both zeroed by a restart
	always_ff @(posedge aclk) begin
		if (!aresetn || restart || !run) begin
			pre_r  <= '0;
			tick_r <= '0;
			expire <= 1'b0;
		end else begin
			pre_r  <= tick ? '0 : pre_r + 32'h1;
			expire <= 1'b0;
			if (tick) begin
				if (tick_r == 32'(LIMIT_TICKS - 1)) begin
					tick_r <= '0;
					expire <= 1'b1;
				end else begin
					tick_r <= tick_r + 32'h1;
				end
			end
		end
	end
endmodule : css_timeout
`default_nettype wire

// >>> core/css_buck.sv
// constant off-time buck switching timer with on-time limit
`timescale 1ns/100ps
`default_nettype none
module css_buck #(
	parameter int MAXON_CYC = css_pkg::MAXON_CYC
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// controller side
	css_buck_if.pwr   bk
);
	import css_pkg::*;
	typedef enum logic [1:0] {BK_IDLE, BK_ON, BK_OFF} css_bk_t;
	css_bk_t     st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	// off-time falls with pack voltage so ripple stays fixed
	function automatic logic [31:0] off_time(input logic [PV_W-1:0] v);
		logic [31:0] q;
		q = (v == '0) ? 32'(TOFF_VCYC) : 32'(TOFF_VCYC) / 32'(v);
		return (q == 32'h0) ? 32'h1 : q;
	endfunction : off_time
	// next state of the switching cycle
	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			BK_IDLE: if (bk.run) begin
				st_nxt  = BK_ON;
				cnt_nxt = '0;
			end
			BK_ON: if (!bk.run) begin
				st_nxt = BK_IDLE;
			end else if (bk.trip) begin
				st_nxt  = BK_OFF;
				cnt_nxt = off_time(bk.pack_v) - 32'h1;
			end else if (cnt_r == 32'(MAXON_CYC - 1)) begin
				st_nxt  = BK_OFF;
				cnt_nxt = 32'(DROP_OFF_CYC - 1);
			end else begin
				cnt_nxt = cnt_r + 32'h1;
			end
			BK_OFF: if (!bk.run) begin
				st_nxt = BK_IDLE;
			end else if (cnt_r == '0) begin
				st_nxt = BK_ON;
			end else begin
				cnt_nxt = cnt_r - 32'h1;
			end
		endcase
	end
	// state and counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r  <= BK_IDLE;
			cnt_r <= '0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// gates registered from next state; never both high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bk.hs <= 1'b0;
			bk.ls <= 1'b0;
		end else begin
			bk.hs <= (st_nxt == BK_ON);
			bk.ls <= (st_nxt == BK_OFF);
		end
	end
endmodule : css_buck
`default_nettype wire

// >>> core/css_top.sv
// charge safety supervisor top with axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none
module css_top #(
	parameter int TICK_CYC      = css_pkg::TICK_CYC,
	parameter int TIMEOUT_TICKS = css_pkg::TIMEOUT_TICKS,
	parameter int MAXON_CYC     = css_pkg::MAXON_CYC
) (
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite write address
	input  wire logic [css_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// axi4-lite read
	input  wire logic [css_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// comparator pins, asynchronous
	input  wire logic                        temp_open_cmp,
	input  wire logic                        temp_cold_cmp,
	input  wire logic                        temp_hot_cmp,
	input  wire logic                        temp_short_cmp,
	input  wire logic                        src_hi_cmp,
	input  wire logic                        src_lo_cmp,
	input  wire logic                        load_hi_cmp,
	input  wire logic                        load_lo_cmp,
	input  wire logic                        adapter_detect,
	input  wire logic                        current_trip,
	input  wire logic [css_pkg::PV_W-1:0]    pack_voltage_input,
	// drives
	output logic                             source_switch_drive,
	output logic                             load_switch_drive,
	output logic                             high_side_gate_out,
	output logic                             low_side_gate_out,
	output logic                             charge_active,
	output logic                             int_n
);
	import css_pkg::*;

	localparam int SYN_W = 10 + PV_W;  // synchronised pin count

	// two-stage synchronisers for every pin
	logic [SYN_W-1:0] syn1_r;          // first stage, read only by stage two
	logic [SYN_W-1:0] syn2_r;          // usable copy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			syn1_r <= '0;
			syn2_r <= '0;
		end else begin
			syn1_r <= {pack_voltage_input, current_trip, adapter_detect,
				load_lo_cmp, load_hi_cmp, src_lo_cmp, src_hi_cmp,
				temp_short_cmp, temp_hot_cmp, temp_cold_cmp, temp_open_cmp};
			syn2_r <= syn1_r;
		end
	end
	logic t_open, t_cold, t_hot, t_short;
	logic s_hi, s_lo, l_hi, l_lo, ac_s, trip_s;
	assign {trip_s, ac_s, l_lo, l_hi, s_lo, s_hi} = syn2_r[9:4];
	// each comparator is its own flag, several may be high at once
	assign {t_short, t_hot, t_cold, t_open} = syn2_r[3:0];

	// register state
	logic [15:0] mode_r;              // mode settings
	logic [15:0] iset_r;              // current setpoint
	logic [15:0] vset_r;              // voltage setpoint
	logic        hot_r;               // latched hot flag
	logic        tmo_r;               // charging ended by timeout
	logic        got_v_r, got_i_r;    // setpoints seen since timeout
	logic        src_on_r;            // source comparator with hysteresis
	logic        load_on_r;           // load comparator with hysteresis
	logic        pack_prev_r;         // pack presence last cycle
	logic [2:0]  watch_prev_r;        // interrupt sources last cycle
	logic        int_pend_r;          // interrupt waiting for a command

	// axi write channel bookkeeping
	logic              aw_held_r, w_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              wr_go;         // both halves present, response free
	logic              wr_mode, wr_iset, wr_vset, wr_hit;
	assign wr_go   = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_mode = wr_go && (aw_addr_r == OFS_MODE);
	assign wr_iset = wr_go && (aw_addr_r == OFS_ISET);
	assign wr_vset = wr_go && (aw_addr_r == OFS_VSET);
	assign wr_hit  = wr_mode || wr_iset || wr_vset;

	// merges byte lanes of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = old;
		if (s[0]) merge16[7:0]  = d[7:0];
		if (s[1]) merge16[15:8] = d[15:8];
	endfunction : merge16

	// soft power-on: open sense, pack removal or mode reset request
	logic pack_present, removal, por_req, soft_por;
	assign pack_present = !t_open;
	assign removal      = pack_prev_r && !pack_present;
	assign por_req      = wr_mode && w_strb_r[0] && w_data_r[MD_POR_BIT];
	assign soft_por     = t_open || removal || por_req;

	// write address and data are taken independently, in any order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r     <= 1'b0;
			s_axi_awready <= 1'b0;
			aw_addr_r     <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_r <= 1'b0;
			end
			// ready only while the holding slot is empty
			s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r     <= 1'b0;
			s_axi_wready <= 1'b0;
			w_data_r     <= '0;
			w_strb_r     <= '0;
		end else begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_r <= 1'b0;
			end
			s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// write response, error for the status word and unmapped offsets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// mode register; the reset request bit is not stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= MODE_POR;
		end else if (wr_mode) begin
			mode_r <= merge16(mode_r, w_data_r, w_strb_r)
				& ~(16'h0001 << MD_POR_BIT);
		end
	end

	// setpoints return to defaults on any soft power-on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			iset_r <= ISET_POR;
			vset_r <= VSET_POR;
		end else if (soft_por) begin
			iset_r <= ISET_POR;
			vset_r <= VSET_POR;
		end else begin
			if (wr_iset) iset_r <= merge16(iset_r, w_data_r, w_strb_r);
			if (wr_vset) vset_r <= merge16(vset_r, w_data_r, w_strb_r);
		end
	end

	// hot flag latches; a live hot reading wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hot_r <= 1'b0;
		end else if (t_hot) begin
			hot_r <= 1'b1;
		end else if (soft_por) begin
			hot_r <= 1'b0;
		end
	end

	// safety timer: restarted by every setpoint command
	logic tmo_expire, tmo_restart;
	assign tmo_restart = wr_iset || wr_vset || soft_por;
	css_timeout #(
		.TICK_CYC    (TICK_CYC),
		.LIMIT_TICKS (TIMEOUT_TICKS)
	) u_timeout (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (!tmo_r),
		.restart (tmo_restart),
		.expire  (tmo_expire)
	);

	// timeout state; both setpoints or a soft power-on end it
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_por) begin
			tmo_r   <= 1'b0;
			got_v_r <= 1'b0;
			got_i_r <= 1'b0;
		end else if (tmo_expire) begin
			tmo_r   <= 1'b1;
			got_v_r <= 1'b0;
			got_i_r <= 1'b0;
		end else if (tmo_r) begin
			got_v_r <= got_v_r || wr_vset;
			got_i_r <= got_i_r || wr_iset;
			// the pack must send both before charging resumes
			if ((got_v_r || wr_vset) && (got_i_r || wr_iset)) begin
				tmo_r   <= 1'b0;
				got_v_r <= 1'b0;
				got_i_r <= 1'b0;
			end
		end
	end

	// charging permission; the cold flag is deliberately not used
	logic chg_ok;
	assign chg_ok = !tmo_r && pack_present
		&& !(hot_r && mode_r[MD_HALT_BIT])
		&& (iset_r >= ISET_MIN) && (vset_r >= VSET_MIN);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			charge_active <= 1'b0;
		end else begin
			charge_active <= chg_ok;
		end
	end

	// switch comparators with hysteresis
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_on_r  <= 1'b0;
			load_on_r <= 1'b1;
		end else begin
			if (s_hi) src_on_r <= 1'b1;
			else if (!s_lo) src_on_r <= 1'b0;
			if (l_hi) load_on_r <= 1'b0;
			else if (!l_lo) load_on_r <= 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			source_switch_drive <= 1'b0;
			load_switch_drive   <= 1'b0;
		end else begin
			source_switch_drive <= src_on_r;
			load_switch_drive   <= load_on_r;
		end
	end

	// interrupt: unmasked changes set, commands clear, set wins
	logic       supply_loss;
	logic [2:0] watch, imask, ichg;
	assign supply_loss = !src_on_r;
	assign watch = {ac_s, pack_present, supply_loss};
	assign imask = {mode_r[MD_ACM_BIT], mode_r[MD_PKM_BIT], mode_r[MD_PFM_BIT]};
	assign ichg  = (watch ^ watch_prev_r) & ~imask;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watch_prev_r <= 3'h0;
			pack_prev_r  <= 1'b0;
			int_pend_r   <= 1'b0;
			int_n        <= 1'b1;
		end else begin
			watch_prev_r <= watch;
			pack_prev_r  <= pack_present;
			if (|ichg) int_pend_r <= 1'b1;
			else if (wr_hit) int_pend_r <= 1'b0;
			int_n <= !int_pend_r;
		end
	end

	// status word assembled from live state
	logic [15:0] status;
	always_comb begin
		status               = 16'h0000;
		status[ST_CHG_BIT]   = chg_ok;
		status[ST_TMO_BIT]   = tmo_r;
		status[ST_SHORT_BIT] = t_short;
		status[ST_HOT_BIT]   = hot_r;
		status[ST_COLD_BIT]  = t_cold;
		status[ST_OPEN_BIT]  = t_open;
		status[ST_PF_BIT]    = supply_loss;
		status[ST_PACK_BIT]  = pack_present;
		status[ST_AC_BIT]    = ac_s;
	end

	// read channel, one read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			unique case (s_axi_araddr)
				OFS_MODE:   s_axi_rdata <= {16'h0000, mode_r};
				OFS_ISET:   s_axi_rdata <= {16'h0000, iset_r};
				OFS_VSET:   s_axi_rdata <= {16'h0000, vset_r};
				OFS_STATUS: s_axi_rdata <= {16'h0000, status};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// buck switching timer
	css_buck_if bk ();
	assign bk.run    = chg_ok;
	assign bk.pack_v = syn2_r[SYN_W-1:10];
	assign bk.trip   = trip_s;
	css_buck #(
		.MAXON_CYC (MAXON_CYC)
	) u_buck (
		.aclk    (aclk),
		.aresetn (aresetn),
		.bk      (bk.pwr)
	);
	assign high_side_gate_out = bk.hs;
	assign low_side_gate_out  = bk.ls;
endmodule : css_top
`default_nettype wire

// >>> tb/css_chk_props.sv
// pin-level checks on the charge safety supervisor
`timescale 1ns/100ps
`default_nettype none
module css_chk #(
	parameter int TICK_CYC      = 4,
	parameter int TIMEOUT_TICKS = 5,
	parameter int MAXON_CYC     = 20
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write path
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	// comparators
	input wire logic temp_open_cmp,
	input wire logic src_hi_cmp,
	input wire logic src_lo_cmp,
	input wire logic load_hi_cmp,
	input wire logic load_lo_cmp,
	// drives
	input wire logic source_switch_drive,
	input wire logic load_switch_drive,
	input wire logic high_side_gate_out,
	input wire logic charge_active
);
	// slack covers restart and status latency
	localparam int LIM = TICK_CYC * TIMEOUT_TICKS + 8;
	localparam int DRP = css_pkg::DROP_OFF_CYC;
	int   tmo_c; // cycles since a possible restart
	int   on_c;  // high side on samples
	int   off_c; // high side off samples
	logic frc;   // last on-phase hit the limit
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// any write or open pack may restart the timer, so restart here too
	always_ff @(posedge aclk) begin
		if (!aresetn || (s_axi_wvalid && s_axi_wready) || temp_open_cmp)
			tmo_c <= 0;
		else if (tmo_c < LIM)
			tmo_c <= tmo_c + 1;
	end
	// phase lengths of the high side gate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_c <= 0;
			off_c <= 0;
			frc <= 1'b0;
		end else begin
			on_c <= high_side_gate_out ? on_c + 1 : 0;
			off_c <= high_side_gate_out ? 0 : off_c + 1;
			// a halted regulator restarts with a plain on-phase, so drop the mark
			if (!charge_active)
				frc <= 1'b0;
			else if (high_side_gate_out)
				frc <= on_c >= MAXON_CYC - 1;
		end
	end
	property p_src_on; src_hi_cmp [*4] |=> source_switch_drive; endproperty
	a_src_on: assert property (p_src_on)
		else $error("source switch stays off");
	property p_src_off; !src_lo_cmp [*4] |=> !source_switch_drive; endproperty
	a_src_off: assert property (p_src_off)
		else $error("source switch stays on");
	property p_ld_off; load_hi_cmp [*4] |=> !load_switch_drive; endproperty
	a_ld_off: assert property (p_ld_off)
		else $error("load switch stays on");
	property p_ld_on; !load_lo_cmp [*4] |=> load_switch_drive; endproperty
	a_ld_on: assert property (p_ld_on)
		else $error("load switch stays off");
	property p_open; temp_open_cmp [*6] |=> !charge_active; endproperty
	a_open: assert property (p_open)
		else $error("charging with open sense");
	property p_tmo; tmo_c == LIM |-> !charge_active; endproperty
	a_tmo: assert property (p_tmo)
		else $error("charging past timeout");
	property p_maxon; high_side_gate_out |-> on_c <= MAXON_CYC; endproperty
	a_maxon: assert property (p_maxon)
		else $error("on-phase too long");
	property p_drop; $rose(high_side_gate_out) && frc |-> off_c inside {[DRP:DRP+2]}; endproperty
	a_drop: assert property (p_drop)
		else $error("dropout off-phase wrong length");
	property p_wbusy; s_axi_bvalid |-> !s_axi_wready; endproperty
	a_wbusy: assert property (p_wbusy)
		else $error("write data taken during response");
endmodule : css_chk
bind css_top css_chk #(.TICK_CYC(TICK_CYC), .TIMEOUT_TICKS(TIMEOUT_TICKS),
	.MAXON_CYC(MAXON_CYC)) u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.temp_open_cmp(temp_open_cmp), .src_hi_cmp(src_hi_cmp), .src_lo_cmp(src_lo_cmp),
	.load_hi_cmp(load_hi_cmp), .load_lo_cmp(load_lo_cmp),
	.source_switch_drive(source_switch_drive), .load_switch_drive(load_switch_drive),
	.high_side_gate_out(high_side_gate_out), .charge_active(charge_active));
`default_nettype wire

// >>> tb/css_pack_m.sv
// pack side model: sense resistance and adapter level to comparator levels
`timescale 1ns/100ps
`default_nettype none
module css_pack_m (
	// sense ohms, adapter minus pack in mV
	input  var int     res,
	input  var int     dv,
	// open cold hot short, source hi lo, load hi lo
	output logic [7:0] c
);
	// every threshold judged alone, so one value may trip several
	assign c = {res > 100000, res > 30000, res < 3000, res < 500,
		dv >= 300, dv > 100, dv >= -100, dv > -300};
endmodule : css_pack_m
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the charge safety supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import css_pkg::*;
	localparam int TK = 4;  // short tick
	localparam int TT = 50; // timeout of 200 cycles
	localparam int MX = 20; // short on-time limit
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat;
	logic        awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, adet = 0, trip = 0;
	logic [4:0]  pv = 5'h0b;
	int          res = 10000, dv = -1000;
	logic [7:0]  c;
	logic        awr, wrd, bv, arr, rv, src, ld, hs, ls, chg, int_n;
	logic [1:0]  br, rr, eb[$];
	logic [33:0] er[$], em[$];
	logic [31:0] rs = 32'h47e7;
	int          bad_count = 0, checks_done = 0;
	css_top #(.TICK_CYC(TK), .TIMEOUT_TICKS(TT), .MAXON_CYC(MX)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rrd), .temp_open_cmp(c[7]), .temp_cold_cmp(c[6]),
		.temp_hot_cmp(c[5]), .temp_short_cmp(c[4]), .src_hi_cmp(c[3]), .src_lo_cmp(c[2]),
		.load_hi_cmp(c[1]), .load_lo_cmp(c[0]), .adapter_detect(adet),
		.current_trip(trip), .pack_voltage_input(pv), .source_switch_drive(src),
		.load_switch_drive(ld), .high_side_gate_out(hs), .low_side_gate_out(ls),
		.charge_active(chg), .int_n(int_n));
	css_pack_m pk (.res(res), .dv(dv), .c(c));
	always #4 aclk = ~aclk;
	function automatic logic [31:0] lf(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lf
	task automatic end_sim;
		if (bad_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic cmp(input string nm, input logic [33:0] e, g, m);
		checks_done++;
		if ((g & m) !== (e & m)) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", nm, e & m, g & m);
		end
	endtask : cmp
	task automatic chk(input string nm, input logic e, g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s exp %b got %b", nm, e, g);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(posedge aclk);
	endtask : w
	// write: address and data offered together, bready held until response
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		eb.push_back(e);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		brd <= 1;
		n = 0;
		do begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wrd) wv <= 0;
			n++;
		end while (!bv && n < 50);
		brd <= 0;
		if (n == 50) begin
			bad_count++;
			end_sim();
		end
		@(posedge aclk);
	endtask : wr
	// read: the watcher compares data under the mask
	task automatic rd(input logic [7:0] a, input logic [33:0] e, m);
		int n;
		er.push_back(e);
		em.push_back(m);
		ara <= a;
		arv <= 1;
		rrd <= 1;
		n = 0;
		do begin
			@(posedge aclk);
			if (arr) arv <= 0;
			n++;
		end while (!rv && n < 50);
		rrd <= 0;
		if (n == 50) begin
			bad_count++;
			end_sim();
		end
		@(posedge aclk);
	endtask : rd
	// length in cycles of the next whole low side gate pulse
	task automatic off_len(input int e);
		int n = 0;
		int k = 0;
		while (ls && k < 2000) begin
			@(posedge aclk);
			k++;
		end
		while (!ls && k < 2000) begin
			@(posedge aclk);
			k++;
		end
		while (ls && k < 2000) begin
			@(posedge aclk);
			n++;
			k++;
		end
		cmp("off_time", 34'(e), 34'(n), '1);
		if (k == 2000) begin
			bad_count++;
			end_sim();
		end
	endtask : off_len
	task automatic kick;
		wr(OFS_ISET, 32'h100, RESP_OKAY);
		wr(OFS_VSET, 32'h1000, RESP_OKAY);
	endtask : kick
	// watcher: oldest note against each response
	always @(posedge aclk) begin
		if (bv && brd) cmp("bresp", {eb.pop_front(), 32'h0}, {br, 32'h0}, '1);
		if (rv && rrd) cmp("read", er.pop_front(), {rr, rdat}, em.pop_front());
	end
	initial begin
		int i;
		int tab[7] = '{400, 200, 50, -200, -400, -200, 200};
		logic [6:0] xs = 7'b0000011; // source expected per step
		logic [6:0] xl = 7'b0110000; // load expected per step
		w(5);
		aresetn <= 1;
		w(10);
		rd(OFS_MODE, 34'h4, '1);
		rd(OFS_ISET, 34'h80, '1);
		rd(OFS_VSET, 34'h4800, '1);
		rd(8'h10, {RESP_SLVERR, 32'h0}, '1);
		chk("charge", 1, chg);
		chk("int_n", 0, int_n);
		wr(OFS_MODE, 32'h4, RESP_OKAY);
		w(2);
		chk("int_n", 1, int_n);
		adet <= 1;
		w(6);
		chk("int_n", 0, int_n);
		wr(OFS_MODE, 32'h14, RESP_OKAY);
		adet <= 0;
		w(6);
		chk("int_n", 1, int_n);
		wr(OFS_STATUS, 32'h0, RESP_SLVERR);
		for (i = 0; i < 5; i++) begin
			rs = lf(rs);
			wr(i[0] ? OFS_VSET : OFS_ISET, {rs[31:16], 4'h1, rs[11:0]}, RESP_OKAY);
			w(120);
			chk("charge", 1, chg);
		end
		rd(OFS_ISET, {18'h0, 4'h1, rs[11:0]}, '1);
		w(220);
		chk("charge", 0, chg);
		rd(OFS_STATUS, 34'h2, 34'h300000003);
		wr(OFS_ISET, 32'h100, RESP_OKAY);
		w(4);
		chk("charge", 0, chg);
		wr(OFS_VSET, 32'h1000, RESP_OKAY);
		w(4);
		chk("charge", 1, chg);
		res <= 450;
		w(8);
		rd(OFS_STATUS, 34'h300, 34'h300000f01);
		chk("charge", 0, chg);
		wr(OFS_MODE, 32'h0, RESP_OKAY);
		w(4);
		chk("charge", 1, chg);
		res <= 10000;
		w(8);
		rd(OFS_STATUS, 34'h200, 34'h300000200);
		wr(OFS_MODE, 32'h5, RESP_OKAY);
		rd(OFS_STATUS, 34'h0, 34'h300000200);
		res <= 50000;
		w(8);
		rd(OFS_STATUS, 34'h401, 34'h300000401);
		rd(OFS_ISET, 34'h80, '1);
		wr(OFS_ISET, 32'h200, RESP_OKAY);
		res <= 200000;
		w(8);
		rd(OFS_STATUS, 34'h800, 34'h300004801);
		res <= 10000;
		w(8);
		rd(OFS_ISET, 34'h80, '1);
		for (i = 0; i < 7; i++) begin
			dv <= tab[i];
			w(8);
			chk("source", xs[i], src);
			chk("load", xl[i], ld);
			rd(OFS_STATUS, {20'h0, ~xs[i], 13'h0}, 34'h300002000);
		end
		kick();
		for (i = 0; i < 40; i++) begin
			rs = lf(rs);
			trip <= rs[0];
			pv <= {1'b1, rs[4:1]};
			@(posedge aclk);
		end
		trip <= 1;
		pv <= 5'd25;
		kick();
		off_len(TOFF_VCYC / 25);
		trip <= 0;
		w(150);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
